// *** rtl/fcir_pkg.sv ***
// ****************************************************************
// Shared constants of the flash command index and ECC config bank
// ****************************************************************
package fcir_pkg;

    // ************************************************************
    // Register byte addresses on the APB
    // ************************************************************
    localparam logic [7:0] FCIR_OFS_CMD_INDEX   = 8'h00;
    localparam logic [7:0] FCIR_OFS_FACTORY_RSV = 8'h04;
    localparam logic [7:0] FCIR_OFS_FLASH_CFG   = 8'h08;
    localparam logic [7:0] FCIR_OFS_ERROR_CFG   = 8'h0c;
    localparam logic [7:0] FCIR_OFS_IRQ_STATUS  = 8'h10;
    localparam logic [7:0] FCIR_OFS_IRQ_MASK    = 8'h14;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int FCIR_BIT_CMD_DONE_IE   = 7;
    localparam int FCIR_BIT_SUPPRESS_SF   = 4;
    localparam int FCIR_BIT_FORCE_DF      = 1;
    localparam int FCIR_BIT_FORCE_SF      = 0;
    localparam int FCIR_BIT_DF_IE         = 1;
    localparam int FCIR_BIT_SF_IE         = 0;
    // Interrupt status and mask layout
    localparam int FCIR_EVT_CMD_DONE      = 0;
    localparam int FCIR_EVT_SINGLE_FAULT  = 1;
    localparam int FCIR_EVT_DOUBLE_FAULT  = 2;
    localparam int FCIR_EVT_W             = 3;

    // ************************************************************
    // Reset values and write masks
    // ************************************************************
    localparam logic [7:0] FCIR_RST_CMD_INDEX   = 8'h00;
    localparam logic [7:0] FCIR_RST_FACTORY_RSV = 8'h00;
    localparam logic [7:0] FCIR_RST_FLASH_CFG   = 8'h00;
    localparam logic [7:0] FCIR_RST_ERROR_CFG   = 8'h00;
    localparam logic [2:0] FCIR_RST_IRQ         = 3'h0;
    localparam logic [7:0] FCIR_MASK_FLASH_CFG  = 8'h93;
    localparam logic [7:0] FCIR_MASK_ERROR_CFG  = 8'h03;

endpackage

// *** rtl/fcir_regs.sv ***
`timescale 1ns/1ps
// Operation
// - Index field selects which command object array word is accessed.
// - Command index register: only index field read/write, other bits zero.
// - Factory reserved register reads zero, resets zero, ignores writes.
// - Config bits: done IE 7, suppress 4, force double 1, force single 0.
// - Command done enable set requests interrupt while done flag set.
// - Suppress single fault blocks single fault reports and their interrupt.
// - Force double fault makes every array read set the double flag.
// - Double fault interrupt only while double fault enable is set.
// - Without forcing, double flag set only by a real double error.
// - Forced double read leaves ECC capture alone unless error is genuine.
// - Force single fault makes each unsuppressed read set single flag; IRQ needs enable.
// - Without forcing, single flag set only by a real single error.
// - Forced single read leaves ECC capture alone unless error is genuine.
// - All implemented error config bits are readable and writable.
// - Error config: double fault enable bit 1, single fault enable bit 0.
// - Command done flag reads one when done, zero while in progress.
module fcir_regs
    import fcir_pkg::*;
#(
    parameter int IDX_W = 3
) (
    // Clock, reset, enable
    input  wire logic             i_core_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_clk_en,
    // APB slave
    input  wire logic             i_psel,
    input  wire logic             i_penable,
    input  wire logic             i_pwrite,
    input  wire logic [7:0]       i_paddr,
    input  wire logic [31:0]      i_pwdata,
    output logic                  o_pready,
    output logic [31:0]           o_prdata,
    output logic                  o_pslverr,
    // Flash controller side
    input  wire logic             i_cmd_done_flag,
    input  wire logic             i_array_read,
    input  wire logic             i_real_single_fault,
    input  wire logic             i_real_double_fault,
    input  wire logic             i_single_fault_flag,
    input  wire logic             i_double_fault_flag,
    output logic [IDX_W-1:0]      o_command_word_index,
    output logic                  o_single_fault_set,
    output logic                  o_double_fault_set,
    output logic                  o_ecc_capture_en,
    // Interrupt requests
    output logic                  o_cmd_done_irq,
    output logic                  o_single_fault_irq,
    output logic                  o_double_fault_irq,
    output logic                  o_irq
);

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [IDX_W-1:0]     index_reg;
    logic [7:0]           flash_cfg_reg;
    logic [7:0]           error_cfg_reg;
    logic [FCIR_EVT_W-1:0] irq_status_reg;
    logic [FCIR_EVT_W-1:0] irq_mask_reg;
    logic                 cmd_done_d_reg;
    logic [31:0]          rdata_next;
    logic                 addr_ok;
    logic                 wr_fire;
    logic                 setup;
    logic                 sf_event;
    logic                 df_event;
    logic [FCIR_EVT_W-1:0] evt;

    // Setup phase, and access phase with the one-cycle answer
    assign setup   = i_psel & ~i_penable;
    assign wr_fire = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;

    // ************************************************************
    // Fault event decode
    // ************************************************************
    // suppress single: masks both real and forced single faults
    assign sf_event = i_array_read & ~flash_cfg_reg[FCIR_BIT_SUPPRESS_SF]
                      & (flash_cfg_reg[FCIR_BIT_FORCE_SF] | i_real_single_fault);
    assign df_event = i_array_read
                      & (flash_cfg_reg[FCIR_BIT_FORCE_DF] | i_real_double_fault);

    // Events seen by the sticky status: done rising, fault sets
    assign evt = {df_event, sf_event, i_cmd_done_flag & ~cmd_done_d_reg};

    // ************************************************************
    // Read decode
    // ************************************************************
    // Decode address and build read word, reserved bits zero
    always_comb begin
        addr_ok    = 1'b1;
        rdata_next = 32'h0000_0000;
        case (i_paddr)
            FCIR_OFS_CMD_INDEX:   rdata_next[IDX_W-1:0] = index_reg;
            FCIR_OFS_FACTORY_RSV: rdata_next[7:0] = FCIR_RST_FACTORY_RSV;
            FCIR_OFS_FLASH_CFG:   rdata_next[7:0] = flash_cfg_reg;
            FCIR_OFS_ERROR_CFG:   rdata_next[7:0] = error_cfg_reg;
            FCIR_OFS_IRQ_STATUS:  rdata_next[FCIR_EVT_W-1:0] = irq_status_reg;
            FCIR_OFS_IRQ_MASK:    rdata_next[FCIR_EVT_W-1:0] = irq_mask_reg;
            default:              addr_ok = 1'b0;
        endcase
    end

    // ************************************************************
    // APB answer
    // ************************************************************
    // Answer prepared in setup so every bus output is a flop
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (i_clk_en) begin
            o_pready  <= setup;
            o_pslverr <= setup & ~addr_ok;
            if (setup && !i_pwrite) begin
                o_prdata <= rdata_next;
            end
        end
    end

    // ************************************************************
    // Command index
    // ************************************************************
    // index steers array word
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            index_reg <= FCIR_RST_CMD_INDEX[IDX_W-1:0];
        end else if (i_clk_en && wr_fire && i_paddr == FCIR_OFS_CMD_INDEX) begin
            index_reg <= i_pwdata[IDX_W-1:0];
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // bit layout via write mask
    // force bits change only by software write or reset
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flash_cfg_reg <= FCIR_RST_FLASH_CFG;
        end else if (i_clk_en && wr_fire && i_paddr == FCIR_OFS_FLASH_CFG) begin
            flash_cfg_reg <= i_pwdata[7:0] & FCIR_MASK_FLASH_CFG;
        end
    end

    // enables at bits 1 and 0
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            error_cfg_reg <= FCIR_RST_ERROR_CFG;
        end else if (i_clk_en && wr_fire && i_paddr == FCIR_OFS_ERROR_CFG) begin
            error_cfg_reg <= i_pwdata[7:0] & FCIR_MASK_ERROR_CFG;
        end
    end

    // ************************************************************
    // Fault and capture strobes
    // ************************************************************
    // forced double sets flag
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_single_fault_set <= 1'b0;
            o_double_fault_set <= 1'b0;
            o_ecc_capture_en   <= 1'b0;
        end else if (i_clk_en) begin
            o_single_fault_set <= sf_event;
            o_double_fault_set <= df_event;
            o_ecc_capture_en   <= i_array_read & (i_real_double_fault
                                  | (i_real_single_fault & ~flash_cfg_reg[FCIR_BIT_SUPPRESS_SF]));
        end
    end

    // Index out, registered to match bus writes
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_command_word_index <= FCIR_RST_CMD_INDEX[IDX_W-1:0];
        end else if (i_clk_en) begin
            o_command_word_index <= index_reg;
        end
    end

    // ************************************************************
    // Interrupt requests
    // ************************************************************
    // done, single fault and double fault interrupts
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_cmd_done_irq     <= 1'b0;
            o_single_fault_irq <= 1'b0;
            o_double_fault_irq <= 1'b0;
        end else if (i_clk_en) begin
            o_cmd_done_irq     <= i_cmd_done_flag & flash_cfg_reg[FCIR_BIT_CMD_DONE_IE];
            // Suppression also blocks a flag left over from before
            o_single_fault_irq <= i_single_fault_flag & error_cfg_reg[FCIR_BIT_SF_IE]
                                  & ~flash_cfg_reg[FCIR_BIT_SUPPRESS_SF];
            o_double_fault_irq <= i_double_fault_flag & error_cfg_reg[FCIR_BIT_DF_IE];
        end
    end

    // Sticky event status; a set in the clearing cycle wins
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_status_reg <= FCIR_RST_IRQ;
            cmd_done_d_reg <= 1'b0;
        end else if (i_clk_en) begin
            cmd_done_d_reg <= i_cmd_done_flag;
            if (wr_fire && i_paddr == FCIR_OFS_IRQ_STATUS) begin
                irq_status_reg <= (irq_status_reg & ~i_pwdata[FCIR_EVT_W-1:0]) | evt;
            end else begin
                irq_status_reg <= irq_status_reg | evt;
            end
        end
    end

    // Mask register and combined interrupt line
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_mask_reg <= FCIR_RST_IRQ;
            o_irq        <= 1'b0;
        end else if (i_clk_en) begin
            if (wr_fire && i_paddr == FCIR_OFS_IRQ_MASK) begin
                irq_mask_reg <= i_pwdata[FCIR_EVT_W-1:0];
            end
            o_irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    chk_index_drives_out: assert property (
        i_clk_en |=> o_command_word_index == $past(index_reg))
        else $error("Index output does not follow the index register");

    chk_index_upper_zero: assert property (
        i_clk_en && setup && !i_pwrite && i_paddr == FCIR_OFS_CMD_INDEX
        |=> o_prdata[31:IDX_W] == '0)
        else $error("Index register upper bits not zero");

    chk_reserved_reads_zero: assert property (
        i_clk_en && setup && !i_pwrite && i_paddr == FCIR_OFS_FACTORY_RSV
        |=> o_prdata == 32'h0000_0000)
        else $error("Factory reserved register did not read zero");

    chk_cfg_reserved_bits: assert property (
        (flash_cfg_reg & ~FCIR_MASK_FLASH_CFG) == 8'h00)
        else $error("Unimplemented configuration bit set");

    chk_done_irq_level: assert property (
        i_clk_en && i_cmd_done_flag && flash_cfg_reg[FCIR_BIT_CMD_DONE_IE] |=> o_cmd_done_irq)
        else $error("Command done interrupt missing");

    chk_suppress_single: assert property (
        i_clk_en && flash_cfg_reg[FCIR_BIT_SUPPRESS_SF] |=> !o_single_fault_set && !o_single_fault_irq)
        else $error("Single fault reported while suppressed");

    chk_force_double: assert property (
        i_clk_en && i_array_read && flash_cfg_reg[FCIR_BIT_FORCE_DF] |=> o_double_fault_set)
        else $error("Forced double fault not reported");

    chk_no_false_double: assert property (
        i_clk_en && !flash_cfg_reg[FCIR_BIT_FORCE_DF] && !i_real_double_fault |=> !o_double_fault_set)
        else $error("Double fault without cause");

    chk_capture_genuine: assert property (
        i_clk_en && !i_real_double_fault && !i_real_single_fault |=> !o_ecc_capture_en)
        else $error("ECC capture without a genuine error");

    chk_force_single: assert property (
        i_clk_en && i_array_read && flash_cfg_reg[FCIR_BIT_FORCE_SF]
        && !flash_cfg_reg[FCIR_BIT_SUPPRESS_SF] |=> o_single_fault_set)
        else $error("Forced single fault not reported");

    // force bit stays without a write
    chk_force_held: assert property (
        flash_cfg_reg[FCIR_BIT_FORCE_SF] && !(wr_fire && i_paddr == FCIR_OFS_FLASH_CFG)
        |=> flash_cfg_reg[FCIR_BIT_FORCE_SF])
        else $error("Force single fault cleared on its own");

    chk_double_irq_gate: assert property (
        i_clk_en && !error_cfg_reg[FCIR_BIT_DF_IE] |=> !o_double_fault_irq)
        else $error("Double fault interrupt without enable");

    // double interrupt follows flag and enable
    chk_double_irq_level: assert property (
        i_clk_en && i_double_fault_flag && error_cfg_reg[FCIR_BIT_DF_IE] |=> o_double_fault_irq)
        else $error("Double fault interrupt missing");

    chk_no_false_single: assert property (
        i_clk_en && !flash_cfg_reg[FCIR_BIT_FORCE_SF] && !i_real_single_fault |=> !o_single_fault_set)
        else $error("Single fault without cause");

    // single interrupt follows flag and enable
    chk_single_irq_level: assert property (
        i_clk_en && i_single_fault_flag && error_cfg_reg[FCIR_BIT_SF_IE]
        && !flash_cfg_reg[FCIR_BIT_SUPPRESS_SF] |=> o_single_fault_irq)
        else $error("Single fault interrupt missing");

    // Enable low must hold software state, or a stalled bus would lose writes
    chk_enable_freezes: assert property (
        !i_clk_en |=> $stable(flash_cfg_reg) && $stable(error_cfg_reg) && $stable(index_reg))
        else $error("Register changed while clock enable low");

    // Scenario coverage
    cov_forced_double: cover property (
        flash_cfg_reg[FCIR_BIT_FORCE_DF] && i_array_read ##1 o_double_fault_set);
    cov_status_clear: cover property (
        wr_fire && i_paddr == FCIR_OFS_IRQ_STATUS && |irq_status_reg);
    cov_bad_address: cover property (o_pready && o_pslverr);
    cov_irq_raised: cover property (!o_irq ##1 o_irq);

endmodule

// *** verification/fcir_flash_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Flash controller read path and error status flags
// ****************************************************************
module fcir_flash_model (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rstn,
    // Fault set pulses from the bank, flag clear from software
    input  wire logic i_single_fault_set,
    input  wire logic i_double_fault_set,
    input  wire logic i_flag_clear,
    // Read path and status levels
    output logic      o_cmd_done_flag,
    output logic      o_array_read,
    output logic      o_real_single_fault,
    output logic      o_real_double_fault,
    output logic      o_single_fault_flag,
    output logic      o_double_fault_flag
);
    // Idle levels at time zero
    initial begin
        o_cmd_done_flag     = 1'b0;
        o_array_read        = 1'b0;
        o_real_single_fault = 1'b1;
        o_real_double_fault = 1'b1;
    end

    // flags are sticky, only a clear or reset drops them
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_single_fault_flag <= 1'b0;
            o_double_fault_flag <= 1'b0;
        end else if (i_flag_clear) begin
            o_single_fault_flag <= 1'b0;
            o_double_fault_flag <= 1'b0;
        end else begin
            o_single_fault_flag <= o_single_fault_flag | i_single_fault_set;
            o_double_fault_flag <= o_double_fault_flag | i_double_fault_set;
        end
    end

    // One read pulse; qualifiers flip afterwards so stale values never look valid
    task automatic array_read(input logic sf, input logic df);
        @(posedge i_core_clk);
        o_array_read        <= 1'b1;
        o_real_single_fault <= sf;
        o_real_double_fault <= df;
        @(posedge i_core_clk);
        o_array_read        <= 1'b0;
        o_real_single_fault <= ~sf;
        o_real_double_fault <= ~df;
    endtask

    // done flag: 1 when finished, 0 while a command runs
    task automatic set_done(input logic v);
        @(posedge i_core_clk);
        o_cmd_done_flag <= v;
    endtask
endmodule

// *** verification/fcir_regs_tb.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Bench for the command index and ECC configuration bank
// ****************************************************************
module fcir_regs_tb;
    import fcir_pkg::*;
    localparam int IDX_W = 3;
    logic             i_core_clk, i_rstn, i_clk_en, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
    logic [7:0]       i_paddr, a;
    logic [31:0]      i_pwdata, o_prdata, rd, d, shadow [4];
    logic [IDX_W-1:0] o_command_word_index;
    logic             done, ard, rsf, rdf, sflag, dflag, fclr, sfs, dfs, ecc, dirq, sirq, firq, o_irq, err;
    int               n_errors, cmp_count, seed;

    fcir_regs #(.IDX_W(IDX_W)) i_fcir_regs (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_cmd_done_flag(done),
        .i_array_read(ard), .i_real_single_fault(rsf), .i_real_double_fault(rdf),
        .i_single_fault_flag(sflag), .i_double_fault_flag(dflag), .o_command_word_index(o_command_word_index),
        .o_single_fault_set(sfs), .o_double_fault_set(dfs), .o_ecc_capture_en(ecc),
        .o_cmd_done_irq(dirq), .o_single_fault_irq(sirq), .o_double_fault_irq(firq), .o_irq(o_irq));
    fcir_flash_model i_fcir_flash_model (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_single_fault_set(sfs), .i_double_fault_set(dfs),
        .i_flag_clear(fclr), .o_cmd_done_flag(done), .o_array_read(ard), .o_real_single_fault(rsf),
        .o_real_double_fault(rdf), .o_single_fault_flag(sflag), .o_double_fault_flag(dflag));

    // 250 MHz core clock
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pin(input string what, input logic exp, input logic got);
        chk_reg(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic conclude;
        $display("counts: %0d comparisons, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Setup, then access held until pready is seen at an edge; no wait count assumed
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        @(posedge i_core_clk);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= wr;
        i_paddr   <= ad;
        i_pwdata  <= wd;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge i_core_clk);
            if (o_pready === 1'b1) break;
        end
        if (n == 16) begin
            n_errors++;
            conclude();
        end else begin
            rd = o_prdata;
            err = o_pslverr;
            i_psel    <= 1'b0;
            i_penable <= 1'b0;
        end
    endtask

    // Writable bits of the index, reserved and config registers, from the field layout
    function automatic logic [31:0] wmask(input logic [7:0] ad);
        case (ad)
            FCIR_OFS_CMD_INDEX: return 32'((1 << IDX_W) - 1);
            FCIR_OFS_FLASH_CFG: return 32'h93;
            FCIR_OFS_ERROR_CFG: return 32'h03;
            default:            return 32'h0;
        endcase
    endfunction

    initial begin
        seed = 32'he4c1;
        n_errors = 0;
        cmp_count = 0;
        {i_rstn, i_psel, i_penable, i_pwrite, fclr, i_paddr, i_pwdata} = '0;
        i_clk_en = 1'b1;
        repeat (6) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        // Reset values, then an unmapped address is refused
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 8'(k * 4), 32'h0);
            chk_reg("reset value", 32'h0, rd);
        end
        apb(1'b1, 8'h18, 32'hffffffff);
        apb(1'b0, 8'h18, 32'h0);
        chk_pin("unmapped error", 1'b1, err);
        chk_reg("unmapped data", 32'h0, rd);
        $display("test reset and unmapped done");
        // Random writes with all-ones corners first; readback shows only the fields
        shadow = '{default: 32'h0};
        for (int k = 0; k < 24; k++) begin
            a = (k < 4) ? 8'(k * 4) : 8'(($random(seed) & 3) * 4);
            d = (k < 4) ? 32'hffffffff : $random(seed);
            apb(1'b1, a, d);
            shadow[a[3:2]] = d & wmask(a);
            apb(1'b0, a, 32'h0);
            chk_reg("register readback", shadow[a[3:2]], rd);
            chk_reg("word index", shadow[0], 32'(o_command_word_index));
        end
        $display("test register access done");
        // Every mix of suppress, force bits and genuine faults on one read
        apb(1'b1, FCIR_OFS_ERROR_CFG, 32'h0);
        for (int k = 0; k < 32; k++) begin
            d = {27'h0, k[4], 2'h0, k[3], k[2]};
            apb(1'b1, FCIR_OFS_FLASH_CFG, d);
            i_fcir_flash_model.array_read(k[0], k[1]);
            @(posedge i_core_clk);
            chk_pin("single set", (k[2] | k[0]) & ~k[4], sfs);
            chk_pin("double set", k[3] | k[1], dfs);
            chk_pin("ecc capture", k[1] | (k[0] & ~k[4]), ecc);
            @(posedge i_core_clk);
            chk_pin("single set ends", 1'b0, sfs);
            apb(1'b0, FCIR_OFS_FLASH_CFG, 32'h0);
            chk_reg("force bits kept", d, rd);
        end
        $display("test fault forcing done");
        // Both flags are set now; each enable gates its own level
        apb(1'b1, FCIR_OFS_FLASH_CFG, 32'h0);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, FCIR_OFS_ERROR_CFG, 32'(k));
            repeat (3) @(posedge i_core_clk);
            chk_pin("single irq", k[0], sirq);
            chk_pin("double irq", k[1], firq);
        end
        fclr <= 1'b1;
        @(posedge i_core_clk);
        fclr <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        chk_pin("irq after clear", 1'b0, sirq | firq);
        $display("test error interrupts done");
        // Command done interrupt, then status and mask of the summary output
        apb(1'b1, FCIR_OFS_IRQ_STATUS, 32'h7);
        apb(1'b1, FCIR_OFS_FLASH_CFG, 32'h80);
        repeat (3) @(posedge i_core_clk);
        chk_pin("done irq busy", 1'b0, dirq);
        i_fcir_flash_model.set_done(1'b1);
        repeat (3) @(posedge i_core_clk);
        chk_pin("done irq", 1'b1, dirq);
        apb(1'b0, FCIR_OFS_IRQ_STATUS, 32'h0);
        chk_reg("irq status", 32'h1, rd);
        apb(1'b1, FCIR_OFS_IRQ_MASK, 32'h1);
        repeat (3) @(posedge i_core_clk);
        chk_pin("irq unmasked", 1'b1, o_irq);
        apb(1'b1, FCIR_OFS_IRQ_STATUS, 32'h1);
        repeat (3) @(posedge i_core_clk);
        chk_pin("irq cleared", 1'b0, o_irq);
        apb(1'b1, FCIR_OFS_FLASH_CFG, 32'h0);
        repeat (3) @(posedge i_core_clk);
        chk_pin("done irq off", 1'b0, dirq);
        $display("test done interrupt done");
        // Clock enable low freezes the done interrupt level while the flag drops
        apb(1'b1, FCIR_OFS_FLASH_CFG, 32'h80);
        @(posedge i_core_clk);
        i_clk_en <= 1'b0;
        i_fcir_flash_model.set_done(1'b0);
        repeat (3) @(posedge i_core_clk);
        chk_pin("frozen done irq", 1'b1, dirq);
        i_clk_en <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        chk_pin("thawed done irq", 1'b0, dirq);
        $display("test clock enable done");
        // Reset in mid-run returns the index, reserved and both config registers to zero; first access right after release
        apb(1'b1, FCIR_OFS_CMD_INDEX, 32'h5);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        chk_pin("irq in reset", 1'b0, dirq | o_irq | sirq | firq);
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 8'(k * 4), 32'h0);
            chk_reg("value after reset", 32'h0, rd);
        end
        chk_reg("word index after reset", 32'h0, 32'(o_command_word_index));
        $display("test mid-run reset done");
        conclude();
    end
endmodule
